// ==== shared/dvp_map.svh ====
// Register offsets, field positions, reset values and encodings
`ifndef DVP_MAP_SVH
`define DVP_MAP_SVH
// ----------------------------------------
// I/O register offsets
// ----------------------------------------
`define DVP_OFS_PATT_PTR 16'h82EE
`define DVP_OFS_PATT_DATA 16'h8EEE
`define DVP_OFS_POINT_IDX 16'h9AEE
`define DVP_OFS_ROW_START_X 16'hB2EE
`define DVP_OFS_ROW_END_X 16'hBEEE
`define DVP_OFS_VERT_DIR 16'hC2EE
`define DVP_OFS_SSV 16'hC6EE
`define DVP_OFS_SCAN_TARGET 16'hCAEE
`define DVP_OFS_PATT_LEN 16'hD2EE
`define DVP_OFS_PATT_PIX 16'hD6EE
`define DVP_OFS_SOURCE_POS_X_RB 16'hDAEE
`define DVP_OFS_SOURCE_POS_Y_RB 16'hDEEE
`define DVP_OFS_POINT_DATA 16'hFEEE
// ----------------------------------------
// Fields and values
// ----------------------------------------
`define DVP_PIDX_CURRENT_POS_X 3'h0
`define DVP_PIDX_CURRENT_POS_Y 3'h1
`define DVP_PIDX_END_X 3'h2
`define DVP_PIDX_END_Y 3'h3
`define DVP_PIDX_BOX_X 3'h4
`define DVP_PIDX_BOX_Y 3'h5
`define DVP_PLEN_TILE_BIT 7
`define DVP_PLEN_BW_BIT 15
`define DVP_MONO_BASE 8'h10
`define DVP_PATT_REGS 8'h18
`define DVP_BOUND_LO_RST 12'h7FF
`define DVP_BOUND_HI_RST 12'h800
`endif

// ==== shared/dvp_pkg.sv ====
// Types shared by the draw front end
package dvp_pkg;
	// Kinds of command handed to the engine
	typedef enum logic [1:0] {
		DVP_CMD_SSV = 2'b00,
		DVP_CMD_LINE = 2'b01,
		DVP_CMD_SPAN = 2'b10
	} dvp_kind_t;
	// One engine command
	typedef struct packed {
		dvp_kind_t kind;
		logic [2:0] dir;
		logic draw;
		logic [3:0] len;
		logic [10:0] x0;
		logic [10:0] y0;
		logic [10:0] x1;
		logic [10:0] y1;
		logic rev;
	} dvp_cmd_t;
endpackage

// ==== rtl/dvp_front_end.sv ====
// Draw engine front end: vectors, point lines, spans, pattern store
`timescale 1ns/1ps
`default_nettype none
`include "dvp_map.svh"

module dvp_front_end
	import dvp_pkg::*;
#(
	parameter int CLK_MHZ = 20
)(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [15:0] i_io_addr,
	input wire logic [15:0] i_io_wdata,
	output logic o_io_ready,
	output logic [15:0] o_io_rdata,
	output logic o_io_rvalid,
	output logic o_cmd_valid,
	input wire logic i_cmd_ready,
	output dvp_cmd_t o_cmd,
	input wire logic [10:0] i_src_pos_x,
	input wire logic [10:0] i_src_pos_y,
	input wire logic i_bounds_clear,
	output logic [11:0] o_bound_left,
	output logic [11:0] o_bound_right,
	output logic [11:0] o_bound_top,
	output logic [11:0] o_bound_bottom,
	output logic [10:0] o_current_pos_x,
	output logic [10:0] o_current_pos_y,
	output logic [10:0] o_row_start_x,
	output logic [10:0] o_row_end_x,
	output logic o_vertical_dir,
	input wire logic i_color_patt_sel,
	input wire logic i_scratch_wr,
	input wire logic [3:0] i_scratch_idx,
	input wire logic [15:0] i_scratch_data,
	input wire logic i_patt_step,
	input wire logic [2:0] i_dest_x,
	input wire logic [2:0] i_dest_y,
	output logic [7:0] o_color_pixel,
	output logic o_mono_bit,
	output logic o_tile_en,
	output logic o_bw_mask_en
);
	if (CLK_MHZ < 1)
		$error("CLK_MHZ must be positive");

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Next point index after a write
	function automatic logic [2:0] next_pidx(input logic [2:0] idx);
		logic [2:0] n;
		n = idx + 3'h1;
		if (idx == `DVP_PIDX_END_Y)
			n = `DVP_PIDX_END_X;
		else if (idx == `DVP_PIDX_BOX_Y)
			n = `DVP_PIDX_BOX_X;
		else if (idx > `DVP_PIDX_BOX_Y)
			n = `DVP_PIDX_CURRENT_POS_X;
		return n;
	endfunction

	// Sign-extend an 11-bit coordinate for bounds compares
	function automatic logic signed [11:0] sx(input logic [10:0] v);
		return signed'({v[10], v});
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [10:0] current_pos_x_q, current_pos_y_q, end_x_q;
	logic [2:0] pidx_q;
	logic [11:0] b_left_q, b_right_q, b_top_q, b_bot_q;
	logic [10:0] row_start_q, row_end_q;
	logic vdir_q, span_flag_q;
	logic [7:0] patt_ptr_q;
	logic [4:0] patt_pix_q, patt_len_q;
	logic tile_q, bw_q;
	logic [15:0] patt_q [24];
	logic [15:0] rdata_q;
	logic rvalid_q;
	dvp_cmd_t buf_q [2];
	logic buf_wp_q, buf_rp_q;
	logic [1:0] buf_cnt_q;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire a_pptr = (i_io_addr == `DVP_OFS_PATT_PTR);
	wire a_pdat = (i_io_addr == `DVP_OFS_PATT_DATA);
	wire a_pidx = (i_io_addr == `DVP_OFS_POINT_IDX);
	wire a_rsx = (i_io_addr == `DVP_OFS_ROW_START_X);
	wire a_rex = (i_io_addr == `DVP_OFS_ROW_END_X);
	wire a_vdir = (i_io_addr == `DVP_OFS_VERT_DIR);
	wire a_ssv = (i_io_addr == `DVP_OFS_SSV);
	wire a_scan = (i_io_addr == `DVP_OFS_SCAN_TARGET);
	wire a_plen = (i_io_addr == `DVP_OFS_PATT_LEN);
	wire a_ppix = (i_io_addr == `DVP_OFS_PATT_PIX);
	wire a_rbx = (i_io_addr == `DVP_OFS_SOURCE_POS_X_RB);
	wire a_rby = (i_io_addr == `DVP_OFS_SOURCE_POS_Y_RB);
	wire a_pt = (i_io_addr == `DVP_OFS_POINT_DATA);

	// ----------------------------------------
	// Write acceptance and command build
	// ----------------------------------------
	// Lines and spans need one free slot, vector pairs need both
	wire pt_draw = a_pt && (pidx_q == `DVP_PIDX_END_Y);
	wire span_draw = a_scan && !span_flag_q;
	wire need1 = pt_draw || span_draw;
	always_comb
	begin
		o_io_ready = 1'b1;
		if (a_ssv)
			o_io_ready = (buf_cnt_q == 2'd0);
		else if (need1)
			o_io_ready = (buf_cnt_q != 2'd2);
	end

	wire wr = i_clk_en && i_io_wr && o_io_ready;
	wire [10:0] wv = i_io_wdata[10:0];
	wire w_pt = wr && a_pt;
	wire w_ssv = wr && a_ssv;
	wire w_line = wr && pt_draw;
	wire w_scan = wr && a_scan;
	wire w_span = wr && span_draw;

	// Vector byte: bits 7:5 direction, bit 4 draw, bits 3:0 length
	dvp_cmd_t ssv_hi, ssv_lo, line_cmd, span_cmd;
	always_comb
	begin
		ssv_hi = '0;
		ssv_hi.kind = DVP_CMD_SSV;
		ssv_hi.dir = i_io_wdata[15:13];
		ssv_hi.draw = i_io_wdata[12];
		ssv_hi.len = i_io_wdata[11:8];
		ssv_hi.x0 = current_pos_x_q;
		ssv_hi.y0 = current_pos_y_q;
		ssv_lo = ssv_hi;
		ssv_lo.dir = i_io_wdata[7:5];
		ssv_lo.draw = i_io_wdata[4];
		ssv_lo.len = i_io_wdata[3:0];
		line_cmd = '0;
		line_cmd.kind = DVP_CMD_LINE;
		line_cmd.draw = 1'b1;
		line_cmd.x0 = current_pos_x_q;
		line_cmd.y0 = current_pos_y_q;
		line_cmd.x1 = end_x_q;
		line_cmd.y1 = wv;
		span_cmd = '0;
		span_cmd.kind = DVP_CMD_SPAN;
		span_cmd.draw = 1'b1;
		span_cmd.rev = (wv < current_pos_x_q);
		span_cmd.x0 = span_cmd.rev ? wv : current_pos_x_q;
		span_cmd.x1 = span_cmd.rev ? current_pos_x_q : wv;
		span_cmd.y0 = current_pos_y_q;
		span_cmd.y1 = current_pos_y_q;
	end

	// ----------------------------------------
	// Two-entry command buffer
	// ----------------------------------------
	wire pop = i_clk_en && o_cmd_valid && i_cmd_ready;
	wire [1:0] push_n = w_ssv ? 2'd2 : ((w_line || w_span) ? 2'd1 : 2'd0);
	assign o_cmd_valid = (buf_cnt_q != 2'd0);
	assign o_cmd = buf_q[buf_rp_q];

	// Buffer pointers and fill count
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			buf_wp_q <= 1'b0;
			buf_rp_q <= 1'b0;
			buf_cnt_q <= 2'd0;
		end
		else if (i_clk_en)
		begin
			buf_wp_q <= buf_wp_q ^ push_n[0];
			buf_rp_q <= buf_rp_q ^ pop;
			buf_cnt_q <= buf_cnt_q + push_n - {1'b0, pop};
		end
	end

	// Buffer storage; upper vector byte runs first
	always_ff @(posedge i_clk_sys)
	begin
		if (w_ssv)
		begin
			buf_q[buf_wp_q] <= ssv_hi;
			buf_q[~buf_wp_q] <= ssv_lo;
		end
		else if (w_line)
			buf_q[buf_wp_q] <= line_cmd;
		else if (w_span)
			buf_q[buf_wp_q] <= span_cmd;
	end

	// ----------------------------------------
	// Point stream, positions and span flag
	// ----------------------------------------
	wire set_x = w_pt && (pidx_q == `DVP_PIDX_CURRENT_POS_X
		|| pidx_q == `DVP_PIDX_BOX_X);
	wire set_y = w_pt && (pidx_q == `DVP_PIDX_CURRENT_POS_Y
		|| pidx_q == `DVP_PIDX_BOX_Y);
	wire box_pt = w_pt && (pidx_q == `DVP_PIDX_BOX_X
		|| pidx_q == `DVP_PIDX_BOX_Y);
	wire [10:0] box_x = (pidx_q == `DVP_PIDX_BOX_X) ? wv : current_pos_x_q;
	wire [10:0] box_y = (pidx_q == `DVP_PIDX_BOX_Y) ? wv : current_pos_y_q;

	// Point index, current and end position
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			pidx_q <= `DVP_PIDX_CURRENT_POS_X;
			current_pos_x_q <= '0;
			current_pos_y_q <= '0;
			end_x_q <= '0;
		end
		else if (i_clk_en)
		begin
			if (wr && a_pidx)
				pidx_q <= i_io_wdata[2:0];
			else if (w_pt)
				pidx_q <= next_pidx(pidx_q);
			if (set_x || w_scan)
				current_pos_x_q <= wv;
			else if (w_line)
				current_pos_x_q <= end_x_q;
			if (set_y || w_line)
				current_pos_y_q <= wv;
			if (w_pt && pidx_q == `DVP_PIDX_END_X)
				end_x_q <= wv;
		end
	end

	// Span flag: cleared by loading X, toggled by each span write
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
			span_flag_q <= 1'b0;
		else if (i_clk_en)
		begin
			if (w_scan)
				span_flag_q <= !span_flag_q;
			else if (set_x)
				span_flag_q <= 1'b0;
		end
	end

	// Bounds accumulator grows around index 4/5 points; a point that
	// meets a clear in the same cycle still counts against fresh bounds
	wire signed [11:0] bl_base = i_bounds_clear ? `DVP_BOUND_LO_RST
		: b_left_q;
	wire signed [11:0] br_base = i_bounds_clear ? `DVP_BOUND_HI_RST
		: b_right_q;
	wire signed [11:0] bt_base = i_bounds_clear ? `DVP_BOUND_LO_RST
		: b_top_q;
	wire signed [11:0] bb_base = i_bounds_clear ? `DVP_BOUND_HI_RST
		: b_bot_q;
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			b_left_q <= `DVP_BOUND_LO_RST;
			b_top_q <= `DVP_BOUND_LO_RST;
			b_right_q <= `DVP_BOUND_HI_RST;
			b_bot_q <= `DVP_BOUND_HI_RST;
		end
		else if (i_clk_en)
		begin
			if (i_bounds_clear || box_pt)
			begin
				b_left_q <= (box_pt && sx(box_x) < bl_base) ? sx(box_x)
					: bl_base;
				b_right_q <= (box_pt && sx(box_x) > br_base) ? sx(box_x)
					: br_base;
				b_top_q <= (box_pt && sx(box_y) < bt_base) ? sx(box_y)
					: bt_base;
				b_bot_q <= (box_pt && sx(box_y) > bb_base) ? sx(box_y)
					: bb_base;
			end
		end
	end

	// ----------------------------------------
	// Blit source and pattern control registers
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			row_start_q <= '0;
			row_end_q <= '0;
			vdir_q <= 1'b0;
			patt_ptr_q <= '0;
			patt_len_q <= '0;
			tile_q <= 1'b0;
			bw_q <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (wr && a_rsx)
				row_start_q <= wv;
			if (wr && a_rex)
				row_end_q <= wv;
			if (wr && a_vdir)
				vdir_q <= i_io_wdata[0];
			if (wr && a_pptr)
				patt_ptr_q <= i_io_wdata[7:0];
			else if (wr && a_pdat)
				patt_ptr_q <= patt_ptr_q + 8'h01;
			if (wr && a_plen)
			begin
				patt_len_q <= i_io_wdata[4:0];
				tile_q <= i_io_wdata[`DVP_PLEN_TILE_BIT];
				bw_q <= i_io_wdata[`DVP_PLEN_BW_BIT];
			end
		end
	end

	// Pixel pointer: wraps after the last pixel of a linear pattern
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
			patt_pix_q <= '0;
		else if (i_clk_en)
		begin
			if (wr && a_ppix)
				patt_pix_q <= i_io_wdata[4:0];
			else if (i_patt_step && !tile_q)
				patt_pix_q <= (patt_pix_q == patt_len_q) ? 5'h00
					: patt_pix_q + 5'h01;
		end
	end

	// Pattern store: host data port, or blit scratch when unselected
	always_ff @(posedge i_clk_sys)
	begin
		if (wr && a_pdat && patt_ptr_q < `DVP_PATT_REGS)
			patt_q[patt_ptr_q[4:0]] <= i_io_wdata;
		else if (i_clk_en && i_scratch_wr && !i_color_patt_sel)
			patt_q[{1'b0, i_scratch_idx}] <= i_scratch_data;
	end

	// ----------------------------------------
	// Pattern pixel selection
	// ----------------------------------------
	// Color: 32 bytes across 0h-Fh, low byte first
	wire [15:0] col_word = patt_q[{1'b0, patt_pix_q[4:1]}];
	wire [4:0] lin_reg = 5'(`DVP_MONO_BASE + {4'h0, patt_pix_q[4]});
	wire [5:0] tile_b = {i_dest_y, i_dest_x};
	wire [4:0] tile_reg = 5'(`DVP_MONO_BASE + {3'h0, tile_b[5:4]});
	wire [15:0] lin_word = patt_q[lin_reg];
	wire [15:0] tile_word = patt_q[tile_reg];
	wire lin_bit = lin_word[patt_pix_q[3:0]];
	wire tile_bit = tile_word[tile_b[3:0]];

	// Pattern outputs; color source also feeds vector drawing
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_color_pixel <= '0;
			o_mono_bit <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_color_pixel <= patt_pix_q[0] ? col_word[15:8]
				: col_word[7:0];
			o_mono_bit <= tile_q ? tile_bit : lin_bit;
		end
	end
	assign o_tile_en = tile_q;
	assign o_bw_mask_en = tile_q && bw_q;

	// ----------------------------------------
	// Readback
	// ----------------------------------------
	wire [15:0] rmux = a_pptr ? {8'h00, patt_ptr_q}
		: a_rbx ? {5'h00, i_src_pos_x}
		: a_rby ? {5'h00, i_src_pos_y}
		: 16'h0000;
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end
		else if (i_clk_en)
		begin
			rvalid_q <= i_io_rd;
			if (i_io_rd)
				rdata_q <= rmux;
		end
	end

	// Output wiring
	assign o_io_rdata = rdata_q;
	assign o_io_rvalid = rvalid_q;
	assign o_bound_left = b_left_q;
	assign o_bound_right = b_right_q;
	assign o_bound_top = b_top_q;
	assign o_bound_bottom = b_bot_q;
	assign o_current_pos_x = current_pos_x_q;
	assign o_current_pos_y = current_pos_y_q;
	assign o_row_start_x = row_start_q;
	assign o_row_end_x = row_end_q;
	assign o_vertical_dir = vdir_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	property p_ssv_pair;
		w_ssv |=> buf_cnt_q == 2'd2 && o_cmd.kind == DVP_CMD_SSV;
	endproperty
	a_ssv_pair: assert property (p_ssv_pair)
		else $error("vector write did not queue two commands");

	property p_ssv_fields;
		w_ssv |=> o_cmd.dir == $past(i_io_wdata[15:13])
			&& o_cmd.draw == $past(i_io_wdata[12])
			&& o_cmd.len == $past(i_io_wdata[11:8]);
	endproperty
	a_ssv_fields: assert property (p_ssv_fields)
		else $error("vector byte decoded wrongly");

	property p_idx_draw;
		w_pt && pidx_q == `DVP_PIDX_END_Y |=> pidx_q == `DVP_PIDX_END_X;
	endproperty
	a_idx_draw: assert property (p_idx_draw)
		else $error("index did not return to 2");

	property p_idx_step;
		w_pt && pidx_q < `DVP_PIDX_END_Y |=> pidx_q == $past(pidx_q) + 3'h1;
	endproperty
	a_idx_step: assert property (p_idx_step)
		else $error("index did not advance");

	property p_bounds;
		box_pt |=> signed'(b_left_q) <= sx($past(box_x))
			&& signed'(b_right_q) >= sx($past(box_x))
			&& signed'(b_top_q) <= sx($past(box_y))
			&& signed'(b_bot_q) >= sx($past(box_y));
	endproperty
	a_bounds: assert property (p_bounds)
		else $error("bounds do not enclose point");

	property p_pptr_inc;
		wr && a_pdat |=> patt_ptr_q == $past(patt_ptr_q) + 8'h01;
	endproperty
	a_pptr_inc: assert property (p_pptr_inc)
		else $error("pattern pointer did not increment");

	property p_span_toggle;
		w_scan |=> span_flag_q != $past(span_flag_q);
	endproperty
	a_span_toggle: assert property (p_span_toggle)
		else $error("span flag did not toggle");

	property p_span_order;
		o_cmd_valid && o_cmd.kind == DVP_CMD_SPAN |-> o_cmd.x0 <= o_cmd.x1;
	endproperty
	a_span_order: assert property (p_span_order)
		else $error("span ends out of order");

	property p_patt_wrap;
		i_clk_en && i_patt_step && !tile_q && !(wr && a_ppix)
			&& patt_pix_q == patt_len_q |=> patt_pix_q == 5'h00;
	endproperty
	a_patt_wrap: assert property (p_patt_wrap)
		else $error("pattern pointer did not wrap");

	property p_mask;
		o_bw_mask_en |-> o_tile_en;
	endproperty
	a_mask: assert property (p_mask)
		else $error("mask without tiling");

	property p_cov_ssv;
		w_ssv ##1 pop ##1 pop;
	endproperty
	c_cov_ssv: cover property (p_cov_ssv);
	property p_cov_line;
		w_line ##[1:4] pop;
	endproperty
	c_cov_line: cover property (p_cov_line);
	property p_cov_full;
		buf_cnt_q == 2'd2 && !i_cmd_ready;
	endproperty
	c_cov_full: cover property (p_cov_full);
endmodule
`default_nettype wire

// ==== test/dvp_host_model.sv ====
// Host processor model: 16-bit register writes and reads
`timescale 1ns/1ps
`default_nettype none

module dvp_host_model (
	input wire logic i_clk_sys,
	input wire logic i_io_ready,
	input wire logic [15:0] i_io_rdata,
	input wire logic i_io_rvalid,
	output logic o_io_wr,
	output logic o_io_rd,
	output logic [15:0] o_io_addr,
	output logic [15:0] o_io_wdata
);
	// Idle bus at time zero
	initial
	begin
		o_io_wr = 1'b0;
		o_io_rd = 1'b0;
		o_io_addr = 16'h0000;
		o_io_wdata = 16'h0000;
	end

	// Whole 16-bit write, held until ready is sampled high
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		int n;
		@(posedge i_clk_sys);
		#1;
		o_io_wr = 1'b1;
		o_io_addr = a;
		o_io_wdata = d;
		n = 0;
		@(negedge i_clk_sys);
		while (i_io_ready !== 1'b1 && n < 400)
		begin
			@(negedge i_clk_sys);
			n++;
		end
		@(posedge i_clk_sys);
		#1;
		o_io_wr = 1'b0;
		o_io_addr = ~a;
		o_io_wdata = ~d;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [15:0] a, output logic [15:0] d,
		output logic v);
		@(posedge i_clk_sys);
		#1;
		o_io_rd = 1'b1;
		o_io_addr = a;
		@(posedge i_clk_sys);
		#1;
		o_io_rd = 1'b0;
		o_io_addr = ~a;
		d = i_io_rdata;
		v = i_io_rvalid;
	endtask
endmodule

`default_nettype wire

// ==== test/draw_engine_vector_pattern_front_end_bench.sv ====
// Self-checking bench with host model and reference model
`timescale 1ns/1ps
`default_nettype none
`include "dvp_map.svh"

module draw_engine_vector_pattern_front_end_bench
	import dvp_pkg::*;
;
	logic i_clk_sys, i_reset, i_clk_en, i_io_wr, i_io_rd, o_io_ready;
	logic o_io_rvalid, o_cmd_valid, i_cmd_ready, i_bounds_clear;
	logic i_color_patt_sel, i_scratch_wr, i_patt_step, o_mono_bit;
	logic o_tile_en, o_bw_mask_en, o_vertical_dir;
	logic [15:0] i_io_addr, i_io_wdata, o_io_rdata, i_scratch_data;
	logic [10:0] i_src_pos_x, i_src_pos_y, o_current_pos_x;
	logic [10:0] o_current_pos_y, o_row_start_x, o_row_end_x;
	logic [11:0] o_bound_left, o_bound_right, o_bound_top, o_bound_bottom;
	logic [3:0] i_scratch_idx;
	logic [2:0] i_dest_x, i_dest_y;
	logic [7:0] o_color_pixel;
	dvp_cmd_t o_cmd;
	dvp_cmd_t exq[$];
	logic [15:0] patt[24];
	logic [31:0] seed;
	int mismatches, n_checks, cyc, idx, cx, cy, ex, fl, bl, br, bt, bb, i;

	dvp_front_end #(.CLK_MHZ(20)) DUT (.*);

	dvp_host_model u_host (.i_clk_sys(i_clk_sys), .i_io_ready(o_io_ready),
		.i_io_rdata(o_io_rdata), .i_io_rvalid(o_io_rvalid),
		.o_io_wr(i_io_wr), .o_io_rd(i_io_rd), .o_io_addr(i_io_addr),
		.o_io_wdata(i_io_wdata));

	// ----------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------
	initial
	begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end

	// Cuts a hang short
	always @(posedge i_clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			close_out();
		end
	end

	task automatic chk(input logic [63:0] s, input logic [63:0] e,
		input string m);
		n_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, m, s, e);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic dvp_cmd_t mk(dvp_kind_t k, int a, int b, int c,
		int d, int r);
		dvp_cmd_t m;
		m = '0;
		m.kind = k;
		m.x0 = 11'(a);
		m.y0 = 11'(b);
		m.x1 = 11'(c);
		m.y1 = 11'(d);
		m.rev = 1'(r);
		return m;
	endfunction

	// Model bounds back to their cleared values
	task automatic bclr;
		bl = 2047;
		br = -2048;
		bt = 2047;
		bb = -2048;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	// Vector word: upper byte first, then lower byte
	task automatic short_stroke_vector(input logic [15:0] w);
		dvp_cmd_t m;
		u_host.wr(`DVP_OFS_SSV, w);
		for (int b = 1; b >= 0; b--)
		begin
			m = '0;
			m.kind = DVP_CMD_SSV;
			{m.dir, m.draw, m.len} = w[8*b+:8];
			exq.push_back(m);
		end
	endtask

	// Point data write and its action on the model
	task automatic pt(input logic [10:0] v);
		int px, py;
		u_host.wr(`DVP_OFS_POINT_DATA, {5'h0, v});
		if (idx == 3)
		begin
			exq.push_back(mk(DVP_CMD_LINE, cx, cy, ex, v, 0));
			cx = ex;
			cy = v;
			idx = 2;
		end
		else
		begin
			cx = (idx == 0 || idx == 4) ? v : cx;
			cy = (idx == 1 || idx == 5) ? v : cy;
			ex = (idx == 2) ? v : ex;
			fl = (idx == 0 || idx == 4) ? 0 : fl;
			idx = (idx == 5) ? 4 : idx + 1;
		end
		// Bounds compare coordinates as signed 11-bit values
		if (idx == 4 || idx == 5)
		begin
			px = (cx > 1023) ? cx - 2048 : cx;
			py = (cy > 1023) ? cy - 2048 : cy;
			bl = (px < bl) ? px : bl;
			br = (px > br) ? px : br;
			bt = (py < bt) ? py : bt;
			bb = (py > bb) ? py : bb;
		end
	endtask

	// Span target write: draws while the fill flag is clear
	task automatic scan(input int t);
		u_host.wr(`DVP_OFS_SCAN_TARGET, 16'(t));
		if (fl == 0)
			exq.push_back(mk(DVP_CMD_SPAN, (t < cx) ? t : cx, cy,
				(t < cx) ? cx : t, cy, t < cx));
		cx = t;
		fl = 1 - fl;
	endtask

	task automatic setidx(input int n);
		u_host.wr(`DVP_OFS_POINT_IDX, 16'(n));
		idx = n;
	endtask

	// Takes one command from the buffer and compares it
	task automatic pop_chk;
		dvp_cmd_t e;
		int n;
		e = exq.pop_front();
		tick(1);
		i_cmd_ready = 1'b1;
		n = 0;
		@(negedge i_clk_sys);
		while (o_cmd_valid !== 1'b1 && n < 100)
		begin
			@(negedge i_clk_sys);
			n++;
		end
		chk(o_cmd.kind, e.kind, "kind");
		if (e.kind == DVP_CMD_SSV)
			chk({o_cmd.dir, o_cmd.draw, o_cmd.len},
				{e.dir, e.draw, e.len}, "ssv");
		else if (e.kind == DVP_CMD_LINE)
			chk({o_cmd.x0, o_cmd.y0, o_cmd.x1, o_cmd.y1},
				{e.x0, e.y0, e.x1, e.y1}, "line");
		else
			chk({o_cmd.x0, o_cmd.y0, o_cmd.x1, o_cmd.rev},
				{e.x0, e.y0, e.x1, e.rev}, "span");
		tick(1);
		i_cmd_ready = 1'b0;
	endtask

	task automatic pix(input int k);
		tick(2);
		chk(o_color_pixel, 8'(patt[k/2] >> (8*(k%2))), "color");
		chk(o_mono_bit, patt[16+k/16][k%16], "mono");
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic v;
		u_host.rd(a, d, v);
		chk(v, 1'b1, "rvalid");
		chk(d, e, "rdata");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{i_reset, i_clk_en, i_color_patt_sel} = 3'b111;
		{i_cmd_ready, i_bounds_clear, i_scratch_wr, i_patt_step} = 4'h0;
		{i_scratch_idx, i_scratch_data, i_dest_x, i_dest_y} = '0;
		{i_src_pos_x, i_src_pos_y} = '0;
		mismatches = 0;
		n_checks = 0;
		cyc = 0;
		fl = 0;
		bclr();
		seed = 32'h61BA;
		tick(3);
		i_reset = 1'b0;
		chk({o_io_ready, o_cmd_valid}, 2'b10, "reset");
		chk({o_bound_left, o_bound_right}, 24'h7FF800, "reset");
		// Vectors, zero length, refusal while the buffer is busy
		short_stroke_vector(16'h3A15);
		pop_chk();
		pop_chk();
		short_stroke_vector(16'h0800);
		seed = lfsr(seed);
		fork
			short_stroke_vector(seed[15:0]);
			begin
				repeat (3) @(negedge i_clk_sys);
				chk(o_io_ready, 1'b0, "refuse");
				repeat (2) pop_chk();
			end
		join
		repeat (2) pop_chk();
		$display("test vectors done");
		// Point lines: Y passes unchanged whatever its value
		setidx(0);
		for (i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			pt(seed[10:0]);
		end
		repeat (2) pop_chk();
		chk({o_current_pos_x, o_current_pos_y}, {11'(cx), 11'(cy)},
			"cur");
		// Bounds accumulation with move-only points
		i_bounds_clear = 1'b1;
		tick(1);
		i_bounds_clear = 1'b0;
		bclr();
		setidx(4);
		for (i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			pt({1'b0, seed[9:0]});
		end
		tick(1);
		chk({o_bound_left, o_bound_right, o_bound_top, o_bound_bottom},
			{12'(bl), 12'(br), 12'(bt), 12'(bb)}, "bounds");
		$display("test points done");
		// Spans: X, then Y, then three targets; the second draws nothing
		setidx(0);
		pt(11'd300);
		pt(11'd77);
		scan(100);
		scan(250);
		pop_chk();
		tick(1);
		chk(o_cmd_valid, 1'b0, "flag set");
		chk(o_current_pos_x, 11'd250, "span x");
		scan(400);
		pop_chk();
		$display("test spans done");
		// Pattern store, mono data packed one bit a pixel
		u_host.wr(`DVP_OFS_PATT_PTR, 16'h0000);
		for (i = 0; i < 24; i++)
		begin
			seed = lfsr(seed);
			patt[i] = seed[15:0];
			u_host.wr(`DVP_OFS_PATT_DATA, patt[i]);
		end
		u_host.wr(`DVP_OFS_PATT_LEN, 16'h001F);
		u_host.wr(`DVP_OFS_PATT_PIX, 16'h0005);
		pix(5);
		u_host.wr(`DVP_OFS_PATT_LEN, 16'h0003);
		u_host.wr(`DVP_OFS_PATT_PIX, 16'h0003);
		pix(3);
		i_patt_step = 1'b1;
		tick(1);
		i_patt_step = 1'b0;
		pix(0);
		// Clock enable low freezes the pixel pointer
		{i_clk_en, i_patt_step} = 2'b01;
		tick(3);
		{i_clk_en, i_patt_step} = 2'b10;
		pix(0);
		// Tiled pattern; bit 15 only with block write on
		u_host.wr(`DVP_OFS_PATT_LEN, 16'h0080);
		seed = lfsr(seed);
		{i_dest_y, i_dest_x} = seed[5:0];
		tick(2);
		chk({o_tile_en, o_bw_mask_en}, 2'b10, "tile");
		chk(o_mono_bit, patt[16+seed[5:4]][seed[3:0]], "tile bit");
		// Mixes assumed paint and leave alone for the mask
		u_host.wr(`DVP_OFS_PATT_LEN, 16'h8080);
		tick(1);
		chk({o_tile_en, o_bw_mask_en}, 2'b11, "mask");
		// Scratch writes land only while the color pattern is unused
		u_host.wr(`DVP_OFS_PATT_LEN, 16'h001F);
		u_host.wr(`DVP_OFS_PATT_PIX, 16'h0006);
		for (i = 0; i < 2; i++)
		begin
			seed = lfsr(seed);
			i_color_patt_sel = 1'(i);
			{i_scratch_wr, i_scratch_idx, i_scratch_data} = {5'h13, seed[15:0]};
			patt[3] = (i == 0) ? seed[15:0] : patt[3];
			tick(1);
			i_scratch_wr = 1'b0;
			pix(6);
		end
		$display("test pattern done");
		// Blit source rows, direction and readback
		seed = lfsr(seed);
		u_host.wr(`DVP_OFS_ROW_START_X, {5'h0, seed[10:0]});
		u_host.wr(`DVP_OFS_ROW_END_X, {5'h0, seed[26:16]});
		u_host.wr(`DVP_OFS_VERT_DIR, 16'h0001);
		tick(1);
		chk({o_row_start_x, o_row_end_x}, {seed[10:0], seed[26:16]},
			"rows");
		chk(o_vertical_dir, 1'b1, "dir");
		u_host.wr(`DVP_OFS_VERT_DIR, 16'h0000);
		tick(1);
		chk(o_vertical_dir, 1'b0, "dir");
		{i_src_pos_x, i_src_pos_y} = seed[21:0];
		rdchk(`DVP_OFS_SOURCE_POS_X_RB, {5'h0, seed[21:11]});
		rdchk(`DVP_OFS_SOURCE_POS_Y_RB, {5'h0, seed[10:0]});
		rdchk(`DVP_OFS_PATT_PTR, 16'h0018);
		rdchk(`DVP_OFS_POINT_IDX, 16'h0000);
		rdchk(16'h1234, 16'h0000);
		$display("test registers done");
		close_out();
	end
endmodule

`default_nettype wire
